/* File: idle_timer.sv */
// Inactivity countdown in whole interval units.
// Assumes restart and arm come from logic on the same clock.
`include "pm_defines.svh"

module idle_timer #(
	parameter int unsigned UNIT_CYCLES = `PM_UNIT_CYCLES
) (
	// Clock, reset and freeze.
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Control.
	input wire logic i_restart,
	input wire logic i_arm,
	input wire pm_pkg::idle_interval_t i_interval,
	// Result.
	output logic o_expire
);
	import pm_pkg::*;

	unit_prescale_t prescale;
	idle_interval_t remaining;
	unit_prescale_t next_prescale;
	idle_interval_t next_remaining;
	logic next_expire;

	wire reload = i_restart | ~i_arm;
	wire unit_done = prescale == unit_prescale_t'(UNIT_CYCLES - 1);
	wire counting = remaining != 11'h000;
	wire last_unit = remaining == 11'h001;

	// A spent count parks at zero, so one arming gives at most one expiry.
	assign next_prescale = (reload | unit_done | ~counting) ? 16'h0000 : prescale + 16'h0001;
	assign next_remaining = reload ? i_interval :
		(unit_done & counting) ? remaining - 11'h001 : remaining;
	assign next_expire = ~reload & unit_done & last_unit;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prescale <= 16'h0000;
			remaining <= 11'h000;
			o_expire <= 1'b0;
		end else if (i_clk_en) begin
			prescale <= next_prescale;
			remaining <= next_remaining;
			o_expire <= next_expire;
		end
	end

	a_reload_interval: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && reload |=> remaining == $past(i_interval))
		else $error("Idle count did not reload from the interval.");

	a_unit_expiry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && !reload && unit_done && last_unit |=> o_expire)
		else $error("Idle timer missed expiry at the last unit.");
endmodule : idle_timer

/* File: pm_defines.svh */
// Offsets, field positions, reset values and timing counts of the power-mode block.
// Assumes it is included by bare name from the package and design files.
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH

// Register offsets on the host register port.
`define PM_OFS_MODE 8'h88
`define PM_OFS_GATES 8'h8a
`define PM_OFS_AUTO 8'h8b
`define PM_OFS_IVL_LO 8'h8c
`define PM_OFS_IVL_HI 8'h8d

// Operating mode field codes and position.
`define PM_MODE_SLEEP 2'h0
`define PM_MODE_RUN 2'h1
`define PM_MODE_LSB 0
`define PM_MODE_MSB 1

// Field positions.
`define PM_BIT_KEYPAD 0
`define PM_BIT_PWM 2
`define PM_BIT_AUTO_EN 0
`define PM_IVL_HI_MSB 2

// Reset values.
`define PM_RST_GATES 8'h00
`define PM_RST_AUTO 1'h0
`define PM_RST_IVL_LO 8'hff
`define PM_RST_IVL_HI 3'h0

// Timing: one interval unit and the clock period.
`define PM_CLK_PERIOD_NS 100
`define PM_UNIT_MS 4
`define PM_UNIT_CYCLES ((`PM_UNIT_MS * 1000000) / `PM_CLK_PERIOD_NS)

`endif

/* File: pm_pkg.sv */
// Types shared by the power-mode block and its idle timer.
// Assumes pm_defines.svh is on the include path.
`include "pm_defines.svh"

package pm_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [10:0] idle_interval_t;
	typedef logic [15:0] unit_prescale_t;
	typedef enum logic [1:0] {
		st_run = 2'b00,
		st_sleep = 2'b01
	} power_state_e;
endpackage : pm_pkg

/* File: power_mode_ctrl.sv */
// Power-mode and clock-gating control registers with the automatic sleep timer.
// Assumes register strobes, processing events and wake come from logic on the same clock.
// How it works
// - Writing 00 to the mode field enters sleep at once, ignoring autosleep.
// - Reading the mode field returns the current mode; it resets to 01.
// - Gate register bit 2 runs the PWM timer clock; resets to zero.
// - Gate register bit 0 runs the keypad scanner clock; resets to zero.
// - Autosleep bit 0 allows automatic sleep when set; resets to zero.
// - With autosleep enabled, an idle interval without events enters sleep.
// - The 11-bit interval spans low and high bytes; one count is 4 ms.
// - A zero interval disables automatic sleep even with the enable set.
// - The interval resets to 0xff low and zero high, about one second.
`include "pm_defines.svh"

module power_mode_ctrl #(
	parameter int unsigned UNIT_CYCLES = `PM_UNIT_CYCLES
) (
	// Clock, reset and freeze.
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// Register port.
	input wire pm_pkg::reg_byte_t i_reg_addr,
	input wire pm_pkg::reg_byte_t i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output pm_pkg::reg_byte_t o_reg_rdata,
	// Activity and wake.
	input wire logic i_proc_event,
	input wire logic i_wake,
	// Power and clock control.
	output logic o_sleep,
	output logic o_keypad_clk_gate,
	output logic o_pwm_clk_gate
);
	import pm_pkg::*;

	// A sized literal cannot be bit-selected, so the reset byte is held here first.
	localparam reg_byte_t GATES_RESET = `PM_RST_GATES;

	power_state_e state;
	power_state_e next_state;
	logic auto_en;
	reg_byte_t ivl_low;
	logic [2:0] ivl_high;
	logic cfg_rewritten;
	reg_byte_t next_rdata;
	logic timer_expire;

	// Address decode.
	wire sel_mode = i_reg_addr == `PM_OFS_MODE;
	wire sel_gates = i_reg_addr == `PM_OFS_GATES;
	wire sel_auto = i_reg_addr == `PM_OFS_AUTO;
	wire sel_ivl_lo = i_reg_addr == `PM_OFS_IVL_LO;
	wire sel_ivl_hi = i_reg_addr == `PM_OFS_IVL_HI;
	wire wr_hit = i_clk_en & i_reg_wr;
	wire rd_hit = i_clk_en & i_reg_rd;
	wire wr_gates = wr_hit & sel_gates;
	wire wr_auto = wr_hit & sel_auto;
	wire wr_ivl_lo = wr_hit & sel_ivl_lo;
	wire wr_ivl_hi = wr_hit & sel_ivl_hi;
	wire wr_cfg = wr_auto | wr_ivl_lo | wr_ivl_hi;

	// Codes 1x are reserved for future modes and leave the mode unchanged.
	wire [1:0] wr_mode = i_reg_wdata[`PM_MODE_MSB:`PM_MODE_LSB];
	wire force_sleep = wr_hit & sel_mode & (wr_mode == `PM_MODE_SLEEP);

	wire running = state == st_run;
	wire [1:0] mode_field = running ? `PM_MODE_RUN : `PM_MODE_SLEEP;
	wire idle_interval_t interval = {ivl_high, ivl_low};
	wire interval_zero = interval == 11'h000;
	// Armed only while running, enabled and with a non-zero interval.
	wire auto_armed = running & auto_en & ~interval_zero;
	wire auto_sleep_hit = timer_expire & auto_armed;
	// A configuration write restarts the timer one cycle later so it reloads the value just written.
	wire timer_restart = i_proc_event | cfg_rewritten | i_wake;

	always_comb begin
		next_state = state;
		case (state)
			st_run: begin
				if (force_sleep | auto_sleep_hit) begin
					next_state = st_sleep;
				end
			end
			st_sleep: begin
				if (i_wake) begin
					next_state = st_run;
				end
			end
			default: begin
				next_state = st_run;
			end
		endcase
	end

	// Unmapped offsets and reserved bits read as zero.
	assign next_rdata = sel_mode ? {6'h00, mode_field} :
		sel_gates ? {5'h00, o_pwm_clk_gate, 1'b0, o_keypad_clk_gate} :
		sel_auto ? {7'h00, auto_en} :
		sel_ivl_lo ? ivl_low :
		sel_ivl_hi ? {5'h00, ivl_high} : 8'h00;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= st_run;
			cfg_rewritten <= 1'b0;
			o_sleep <= 1'b0;
		end else if (i_clk_en) begin
			state <= next_state;
			cfg_rewritten <= wr_cfg;
			o_sleep <= next_state == st_sleep;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_keypad_clk_gate <= GATES_RESET[`PM_BIT_KEYPAD];
			o_pwm_clk_gate <= GATES_RESET[`PM_BIT_PWM];
		end else if (wr_gates) begin
			o_keypad_clk_gate <= i_reg_wdata[`PM_BIT_KEYPAD];
			o_pwm_clk_gate <= i_reg_wdata[`PM_BIT_PWM];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			auto_en <= `PM_RST_AUTO;
		end else if (wr_auto) begin
			auto_en <= i_reg_wdata[`PM_BIT_AUTO_EN];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ivl_low <= `PM_RST_IVL_LO;
		end else if (wr_ivl_lo) begin
			ivl_low <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ivl_high <= `PM_RST_IVL_HI;
		end else if (wr_ivl_hi) begin
			ivl_high <= i_reg_wdata[`PM_IVL_HI_MSB:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (rd_hit) begin
			o_reg_rdata <= next_rdata;
		end
	end

	idle_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_idle_timer (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_restart(timer_restart),
		.i_arm(auto_armed),
		.i_interval(interval),
		.o_expire(timer_expire)
	);

	// Helper for the reset-value check: set once the low byte is written.
	logic ivl_low_written;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ivl_low_written <= 1'b0;
		end else if (wr_ivl_lo) begin
			ivl_low_written <= 1'b1;
		end
	end

	a_forced_sleep_entry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		force_sleep && running |=> o_sleep && state == st_sleep)
		else $error("Writing sleep code did not enter sleep at once.");

	a_mode_readback: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rd_hit && sel_mode && running && !force_sleep |=> o_reg_rdata == 8'h01)
		else $error("Mode read while running did not return the run code.");

	a_pwm_gate_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_gates |=> o_pwm_clk_gate == $past(i_reg_wdata[`PM_BIT_PWM]))
		else $error("PWM clock gate did not follow bit 2.");

	a_keypad_gate_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_gates |=> o_keypad_clk_gate == $past(i_reg_wdata[0]) ##1 $stable(o_keypad_clk_gate)
		|| $past(wr_gates))
		else $error("Keypad clock gate did not follow bit 0.");

	a_auto_disabled_stays: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		running && !auto_en && !force_sleep |=> !o_sleep)
		else $error("Sleep entered with autosleep disabled.");

	a_idle_expiry_sleep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && timer_expire && auto_armed |=> o_sleep)
		else $error("Idle interval elapsed without entering sleep.");

	a_interval_high_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rd_hit && sel_ivl_hi |=> o_reg_rdata == {5'h00, $past(ivl_high)})
		else $error("High interval byte read back wrong.");

	a_zero_interval_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		running && interval_zero && !force_sleep |=> !o_sleep)
		else $error("Automatic sleep with a zero interval.");

	a_interval_reset_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rd_hit && sel_ivl_lo && !ivl_low_written |=> o_reg_rdata == `PM_RST_IVL_LO)
		else $error("Low interval byte lost its reset value.");

	a_event_blocks_sleep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && i_proc_event && running && !force_sleep |=> ##1 !timer_expire)
		else $error("Idle expiry right after a processing event.");

	c_forced_sleep: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		running && force_sleep ##1 o_sleep);

	c_auto_sleep: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		auto_sleep_hit ##1 o_sleep);

	c_wake_up: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		o_sleep && i_wake && i_clk_en ##1 !o_sleep);

	// Helper for the high-byte reset check: set once the high byte is written.
	logic ivl_high_written;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ivl_high_written <= 1'b0;
		end else if (wr_ivl_hi) begin
			ivl_high_written <= 1'b1;
		end
	end

	a_reserved_mode_kept: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_hit && sel_mode && wr_mode[1] && running && !timer_expire |=> !o_sleep)
		else $error("Reserved mode code changed the operating mode.");

	a_sleep_mode_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rd_hit && sel_mode && !running |=> o_reg_rdata == {6'h00, `PM_MODE_SLEEP})
		else $error("Mode read while asleep did not return the sleep code.");

	a_gates_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!wr_gates |=> $stable(o_keypad_clk_gate) && $stable(o_pwm_clk_gate))
		else $error("Clock gate changed without a gate write.");

	a_auto_enable_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_auto |=> auto_en == $past(i_reg_wdata[`PM_BIT_AUTO_EN]))
		else $error("Autosleep enable did not follow bit 0.");

	a_auto_readback: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rd_hit && sel_auto |=> o_reg_rdata == {7'h00, $past(auto_en)})
		else $error("Autosleep register read back wrong.");

	a_interval_low_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_ivl_lo |=> ivl_low == $past(i_reg_wdata))
		else $error("Low interval byte did not take the written value.");

	a_interval_high_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_ivl_hi |=> ivl_high == $past(i_reg_wdata[`PM_IVL_HI_MSB:0]))
		else $error("High interval bits did not take the written value.");

	a_interval_reset_high: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rd_hit && sel_ivl_hi && !ivl_high_written |=> o_reg_rdata == {5'h00, `PM_RST_IVL_HI})
		else $error("High interval byte lost its reset value.");

	a_config_restart: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_cfg ##1 i_clk_en |=> !timer_expire)
		else $error("Idle expiry right after a configuration rewrite.");

	a_wake_exit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en && i_wake && !running |=> !o_sleep)
		else $error("Wake request did not leave sleep.");

	a_sleep_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!running && !i_wake |=> o_sleep)
		else $error("Sleep left without a wake request.");

	a_freeze_state: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!i_clk_en |=> $stable(state) && $stable(o_sleep) && $stable(auto_en))
		else $error("State changed while the clock enable was low.");

	a_sleep_needs_cause: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		running && !force_sleep && !timer_expire |=> !o_sleep)
		else $error("Sleep entered without a forced write or an idle expiry.");

	a_rdata_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!rd_hit |=> $stable(o_reg_rdata))
		else $error("Read data changed without a read.");

	a_unmapped_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rd_hit && !(sel_mode || sel_gates || sel_auto || sel_ivl_lo || sel_ivl_hi)
		|=> o_reg_rdata == 8'h00)
		else $error("Unmapped offset did not read as zero.");

	c_zero_interval: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		running && auto_en && interval_zero ##8 running);

	c_frozen_write: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		i_reg_wr && !i_clk_en ##1 i_clk_en);
endmodule : power_mode_ctrl

/* File: power_mode_ctrl_tb_top.sv */
// Self-checking bench for the power-mode and clock-gating block.
// Assumes pm_pkg and power_mode_ctrl are compiled first; a short interval unit keeps runs brief.
module power_mode_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pm_pkg::*;
	localparam int unsigned U = 4;
	logic i_clock, i_rst_n, i_clk_en, i_reg_wr, i_reg_rd, i_proc_event, i_wake;
	reg_byte_t i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic o_sleep, o_keypad_clk_gate, o_pwm_clk_gate;
	int err_total, n_checks, n;
	reg_byte_t gv [4] = '{8'h01, 8'h04, 8'hff, 8'h00};

	power_mode_ctrl #(.UNIT_CYCLES(U)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
		.i_proc_event(i_proc_event), .i_wake(i_wake), .o_sleep(o_sleep),
		.o_keypad_clk_gate(o_keypad_clk_gate), .o_pwm_clk_gate(o_pwm_clk_gate));

	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic chk8(input string nm, input reg_byte_t exp, input reg_byte_t got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk8

	task automatic chk1(input string nm, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk1

	// The strobe is held until the edge that takes it, then dropped on that same edge.
	task automatic wr(input reg_byte_t a, input reg_byte_t d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input string nm, input reg_byte_t a, input reg_byte_t exp);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
		#1 chk8(nm, exp, o_reg_rdata);
	endtask : rchk

	task automatic wake;
		@(posedge i_clock);
		i_wake <= 1'b1;
		@(posedge i_clock);
		i_wake <= 1'b0;
		#1 chk1("sleep after wake", 1'b0, o_sleep);
	endtask : wake

	// Counts edges until sleep shows, with a bound so a dead timer cannot hang the run.
	task automatic wait_sleep(input int lo, input int hi);
		n = 0;
		#1;
		while (o_sleep !== 1'b1 && n < 1500) begin
			@(posedge i_clock);
			#1 n++;
		end
		chk1("sleep delay in range", 1'b1, n >= lo && n <= hi);
	endtask : wait_sleep

	initial begin
		#(5000 * 100);
		err_total++;
		give_verdict();
	end

	initial begin
		i_rst_n = 1'b0;
		i_clk_en = 1'b1;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_proc_event = 1'b0;
		i_wake = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wdata = 8'h00;
		err_total = 0;
		n_checks = 0;
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		#1 chk1("sleep at reset", 1'b0, o_sleep);
		chk1("keypad gate at reset", 1'b0, o_keypad_clk_gate);
		chk1("pwm gate at reset", 1'b0, o_pwm_clk_gate);
		rchk("mode reset", 8'h88, 8'h01);
		rchk("gates reset", 8'h8a, 8'h00);
		rchk("auto reset", 8'h8b, 8'h00);
		rchk("interval low reset", 8'h8c, 8'hff);
		rchk("interval high reset", 8'h8d, 8'h00);
		rchk("unmapped offset", 8'h89, 8'h00);
		$display("test reset values done");
		foreach (gv[i]) begin
			wr(8'h8a, gv[i]);
			#1 chk1("keypad gate", gv[i][0], o_keypad_clk_gate);
			chk1("pwm gate", gv[i][2], o_pwm_clk_gate);
			rchk("gates readback", 8'h8a, gv[i] & 8'h05);
		end
		$display("test clock gates done");
		wr(8'h88, 8'h02);
		rchk("mode after 02", 8'h88, 8'h01);
		wr(8'h88, 8'h03);
		rchk("mode after 03", 8'h88, 8'h01);
		wr(8'h88, 8'h00);
		#1 chk1("forced sleep", 1'b1, o_sleep);
		rchk("mode while asleep", 8'h88, 8'h00);
		wake();
		rchk("mode after wake", 8'h88, 8'h01);
		@(posedge i_clock);
		i_clk_en <= 1'b0;
		wr(8'h8b, 8'h01);
		i_clk_en <= 1'b1;
		rchk("write while frozen", 8'h8b, 8'h00);
		$display("test mode field done");
		wr(8'h8c, 8'h02);
		wr(8'h8d, 8'h00);
		wr(8'h8b, 8'h01);
		wait_sleep(2 * U, 2 * U + 5);
		wake();
		@(posedge i_clock);
		i_proc_event <= 1'b1;
		repeat (40) @(posedge i_clock);
		i_proc_event <= 1'b0;
		#1 chk1("no sleep under events", 1'b0, o_sleep);
		wait_sleep(2 * U - 1, 2 * U + 5);
		wake();
		wr(8'h8b, 8'h00);
		repeat (100) @(posedge i_clock);
		#1 chk1("no sleep when disabled", 1'b0, o_sleep);
		wr(8'h8c, 8'h00);
		wr(8'h8b, 8'h01);
		repeat (100) @(posedge i_clock);
		#1 chk1("no sleep at zero interval", 1'b0, o_sleep);
		wr(8'h8d, 8'hff);
		rchk("interval high width", 8'h8d, 8'h07);
		wr(8'h8d, 8'h01);
		wait_sleep(256 * U, 256 * U + 5);
		wake();
		$display("test autosleep done");
		give_verdict();
	end
endmodule : power_mode_ctrl_tb_top
